// ### design/hpsc_pkg.sv
/*
 Shared constants and types of the host port: widths, address map of the device's
 I/O space, bit positions, reset values, cycle counts, the controller's register map
 and the state types of both ends. Assumes nothing beyond a SystemVerilog compiler.
*/
package hpsc_pkg;
    localparam int ADDR_W    = 27;
    localparam int DATA_W    = 32;
    localparam int LANES     = 4;
    localparam int MEM_AW    = 4;
    localparam int MEM_DEPTH = 16;
    localparam int IO_SEL_POS = 26;
    localparam int EV_W      = 3;
    localparam int PIN_W     = 5;
    localparam int SYNC_N    = 3;

    localparam logic [1:0] IO_CTRL = 2'h0;
    localparam logic [1:0] IO_STAT = 2'h1;
    localparam logic [1:0] IO_CLR  = 2'h2;
    localparam logic [1:0] IO_EN   = 2'h3;

    localparam int HALT_POS   = 0;
    localparam int INTERRUPT_OUT_BIT_POS = 1;
    localparam int EV_BUS_FAULT_FLAG  = 0;
    localparam int EV_IRQA    = 1;
    localparam int EV_IRQB    = 2;

    localparam int PIN_SEL  = 0;
    localparam int PIN_RD   = 1;
    localparam int PIN_WR   = 2;
    localparam int PIN_IRQA = 3;
    localparam int PIN_IRQB = 4;
    localparam logic [PIN_W-1:0] PIN_RST = 5'h1f;

    localparam logic [1:0] PHASE_TICK  = 2'h3;
    localparam logic [1:0] STRAP_WAIT  = 2'h3;
    localparam logic [4:0] WR_LOW_CYC  = 5'h10;

    localparam logic [7:0] HR_CMD   = 8'h00;
    localparam logic [7:0] HR_ADDR  = 8'h04;
    localparam logic [7:0] HR_BSEL  = 8'h08;
    localparam logic [7:0] HR_WDATA = 8'h0c;
    localparam logic [7:0] HR_RDATA = 8'h10;
    localparam logic [7:0] HR_LIVE  = 8'h14;
    localparam logic [7:0] HR_STAT  = 8'h18;
    localparam logic [7:0] HR_CLR   = 8'h1c;
    localparam logic [7:0] HR_EN    = 8'h20;
    localparam int CMD_START = 0;
    localparam int CMD_WRITE = 1;
    localparam int HEV_DONE  = 0;
    localparam int HEV_IRQ   = 1;

    typedef enum {DS_IDLE, DS_RDFETCH, DS_WRHOLD, DS_WRGATE, DS_DONE} hpsc_dev_state_t;
    typedef enum {HS_IDLE, HS_SETUP, HS_RD, HS_WRLOW, HS_WRWAIT, HS_END} hpsc_host_state_t;
endpackage

// ### design/hpsc_if.sv
/*
 Pins between the host controller and the device's host port, with one modport per end.
 Assumes both ends run on the same clk; the device still synchronises the host strobes.
*/
`timescale 1ns/100ps
interface hpsc_if;
    import hpsc_pkg::*;
    logic                hostSelectN;
    logic [ADDR_W-1:0]   hostLongwordAddress;
    logic [LANES-1:0]    hostByteLaneSel;
    logic                hostRdN;
    logic                hostWrN;
    logic [DATA_W-1:0]   hostWriteData;
    logic [DATA_W-1:0]   readLatchData;
    logic                readLatchStrobe;
    logic                writeLatchOe;
    logic                hostReadyOut;
    logic                hostIrqOut;

    modport dev (input hostSelectN, hostLongwordAddress, hostByteLaneSel, hostRdN, hostWrN,
                 hostWriteData, output readLatchData, readLatchStrobe, writeLatchOe,
                 hostReadyOut, hostIrqOut);
    modport host (output hostSelectN, hostLongwordAddress, hostByteLaneSel, hostRdN, hostWrN,
                  hostWriteData, input readLatchData, readLatchStrobe, writeLatchOe,
                  hostReadyOut, hostIrqOut);
endinterface

// ### design/hpsc_device.sv
/*
 Device end of the host port: synchronised host strobes, address capture, I/O registers,
 a small local memory, host interrupt, boot strap, local clocks and local interrupt inputs.
 Assumes the host holds address, byte lanes and write data stable while its select is low.
*/
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
// How it works
// RQ1: Select low captures address and byte lanes.
// RQ2: Accesses start only while select is low.
// RQ3: Select level at reset release picks boot mode; the strap reads pin_ff before it leaves PIN_RST, so selfBoot stays 0.
// RQ4: Read raises latch strobe to load data.
// RQ5: Interrupt-out bit drives the host interrupt.
// RQ6: Bus faults may also raise host interrupt.
// RQ7: Write cycles assert the write latch enable.
// RQ8: Ready low until access can complete.
// RQ9: Host pairs ready with strobe or enable.
// RQ10: Host read and write strobes active low.
// RQ11: Host never asserts both strobes together.
// RQ12: Write strobe rising edge means data available.
// RQ13: Two local clocks a quarter period apart.
// RQ14: Outputs change with the local clocks; localIrqReq follows pin_ff on every clk.
// RQ15: Local interrupt held low until recognised.
// RQ16: Local interrupts pass a synchroniser first.
// RQ17: Reset sets registers and inactive outputs.
// RQ18: Host-present halts until halt bit cleared.
// RQ19: Ready returns low after strobes removed.
module hpsc_device (
    input  wire logic              clk,
    input  wire logic              reset,
    hpsc_if.dev                    port,
    input  wire logic              localIrqAN,
    input  wire logic              localIrqBN,
    output logic                   localClockA,
    output logic                   localClockB,
    output logic [1:0]             localIrqReq,
    output logic                   cpuRun,
    output logic                   selfBoot
);
    import hpsc_pkg::*;

    logic [PIN_W-1:0]        sync1_ff, sync2_ff, sync3_ff, pin_ff, pinPrev_ff;
    logic [1:0]              phase_ff;
    logic                    tick;
    hpsc_dev_state_t         state_ff;
    logic [ADDR_W-1:0]       addr_ff;
    logic [LANES-1:0]        lanes_ff;
    logic [DATA_W-1:0]       rdData_ff;
    logic                    strobe_ff, oe_ff, ready_ff;
    logic [1:0]              strapCnt_ff;
    logic                    strapDone_ff, hostPresent_ff, halt_ff, interrupt_out_bit_ff;
    logic [EV_W-1:0]         status_ff, enable_ff, nxt_status, events;
    logic [DATA_W-1:0]       mem_ff [MEM_DEPTH];
    logic                    isIo, memHit, wrCommit, rdFetch;
    logic [DATA_W-1:0]       fetchVal;

    // Host strobes and local interrupts pass three flops; a level counts once two agree.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_ff <= PIN_RST;
            sync2_ff <= PIN_RST;
            sync3_ff <= PIN_RST;
        end else begin
            sync1_ff <= {localIrqBN, localIrqAN, port.hostWrN, port.hostRdN, port.hostSelectN};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    generate
        for (genvar i = 0; i < PIN_W; i++) begin : g_pin
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    pin_ff[i] <= PIN_RST[i];
                end else if (sync2_ff[i] == sync3_ff[i]) begin
                    pin_ff[i] <= sync3_ff[i]; // RQ16
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pinPrev_ff <= PIN_RST;
        end else if (tick) begin
            pinPrev_ff <= pin_ff; // RQ14
        end
    end

    assign localIrqReq = ~pin_ff[PIN_IRQB:PIN_IRQA]; // RQ16

    // Local clock phases; the FSM steps once per local clock period.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_ff    <= 2'h0;
            localClockA <= 1'b0;
            localClockB <= 1'b0;
        end else begin
            phase_ff    <= phase_ff + 2'h1;
            localClockA <= phase_ff[0] ^ phase_ff[1] ^ phase_ff[0]; // RQ13
            localClockB <= phase_ff[1] ^ phase_ff[0]; // RQ13
        end
    end

    assign tick = (phase_ff == PHASE_TICK); // RQ14

    // Boot strap: the synchronised select level just after reset release.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strapCnt_ff    <= 2'h0;
            strapDone_ff   <= 1'b0;
            hostPresent_ff <= 1'b1;
        end else if (!strapDone_ff) begin
            strapCnt_ff <= strapCnt_ff + 2'h1;
            if (strapCnt_ff == STRAP_WAIT) begin
                strapDone_ff   <= 1'b1;
                hostPresent_ff <= pin_ff[PIN_SEL]; // RQ3
            end
        end
    end

    assign cpuRun   = strapDone_ff && !halt_ff; // RQ18
    assign selfBoot = strapDone_ff && !hostPresent_ff; // RQ3

    assign isIo     = addr_ff[IO_SEL_POS];
    assign memHit   = (addr_ff[IO_SEL_POS-1:MEM_AW] == '0);
    assign wrCommit = tick && (state_ff == DS_WRGATE);
    assign rdFetch  = tick && (state_ff == DS_RDFETCH);

    always_comb begin
        fetchVal = '0;
        if (isIo) begin
            case (addr_ff[1:0])
                IO_CTRL: fetchVal = {30'h0, interrupt_out_bit_ff, halt_ff};
                IO_STAT: fetchVal = {29'h0, status_ff};
                IO_EN:   fetchVal = {29'h0, enable_ff};
                default: fetchVal = '0;
            endcase
        end else if (memHit) begin
            fetchVal = mem_ff[addr_ff[MEM_AW-1:0]];
        end
    end

    // Host access sequencer.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff  <= DS_IDLE; // RQ17
            addr_ff   <= '0;
            lanes_ff  <= '0;
            rdData_ff <= '0;
            strobe_ff <= 1'b0;
            oe_ff     <= 1'b0;
            ready_ff  <= 1'b0;
        end else if (tick) begin
            case (state_ff)
                DS_IDLE: begin
                    if (strapDone_ff && !pin_ff[PIN_SEL]) begin // RQ2
                        addr_ff  <= port.hostLongwordAddress; // RQ1
                        lanes_ff <= port.hostByteLaneSel; // RQ1
                        if (!pin_ff[PIN_RD]) begin
                            state_ff <= DS_RDFETCH;
                        end else if (!pin_ff[PIN_WR]) begin
                            state_ff <= DS_WRHOLD;
                        end
                    end
                end
                DS_RDFETCH: begin
                    rdData_ff <= fetchVal;
                    strobe_ff <= 1'b1; // RQ4
                    state_ff  <= DS_DONE;
                end
                DS_WRHOLD: begin
                    if (pin_ff[PIN_SEL]) begin
                        state_ff <= DS_IDLE;
                    end else if (pin_ff[PIN_WR]) begin
                        oe_ff    <= 1'b1; // RQ12 RQ7
                        state_ff <= DS_WRGATE;
                    end
                end
                DS_WRGATE: begin
                    ready_ff <= 1'b1; // RQ8
                    state_ff <= DS_DONE;
                end
                DS_DONE: begin
                    ready_ff <= 1'b1; // RQ8
                    if (pin_ff[PIN_SEL] && pin_ff[PIN_RD] && pin_ff[PIN_WR]) begin
                        ready_ff  <= 1'b0; // RQ19
                        strobe_ff <= 1'b0;
                        oe_ff     <= 1'b0;
                        state_ff  <= DS_IDLE;
                    end
                end
                default: state_ff <= DS_IDLE;
            endcase
        end
    end

    assign port.readLatchData   = rdData_ff;
    assign port.readLatchStrobe = strobe_ff;
    assign port.writeLatchOe    = oe_ff;
    assign port.hostReadyOut    = ready_ff;

    // Local memory, written per byte lane; one process keeps the array single-driven.
    always_ff @(posedge clk) begin
        for (int b = 0; b < LANES; b++) begin
            if (wrCommit && !isIo && memHit && lanes_ff[b]) begin
                mem_ff[addr_ff[MEM_AW-1:0]][8*b +: 8] <= port.hostWriteData[8*b +: 8]; // RQ7
            end
        end
    end

    // Control register: halt and interrupt-out bits.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            halt_ff   <= 1'b1; // RQ17
            interrupt_out_bit_ff <= 1'b0;
        end else if (!strapDone_ff && strapCnt_ff == STRAP_WAIT) begin
            halt_ff <= pin_ff[PIN_SEL]; // RQ3
        end else if (wrCommit && isIo && addr_ff[1:0] == IO_CTRL) begin
            halt_ff   <= port.hostWriteData[HALT_POS]; // RQ18
            interrupt_out_bit_ff <= port.hostWriteData[INTERRUPT_OUT_BIT_POS];
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle.
    always_comb begin
        events            = '0;
        events[EV_BUS_FAULT_FLAG] = (rdFetch || wrCommit) && !isIo && !memHit; // RQ6
        events[EV_IRQA]   = pinPrev_ff[PIN_IRQA] && !pin_ff[PIN_IRQA];
        events[EV_IRQB]   = pinPrev_ff[PIN_IRQB] && !pin_ff[PIN_IRQB];
        nxt_status        = status_ff;
        if (wrCommit && isIo && addr_ff[1:0] == IO_CLR) begin
            nxt_status = status_ff & ~port.hostWriteData[EV_W-1:0];
        end
        nxt_status = nxt_status | events;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_ff <= '0;
            enable_ff <= '0;
        end else if (tick) begin
            status_ff <= nxt_status; // RQ14
            if (wrCommit && isIo && addr_ff[1:0] == IO_EN) begin
                enable_ff <= port.hostWriteData[EV_W-1:0];
            end
        end
    end

    assign port.hostIrqOut = interrupt_out_bit_ff || (|(status_ff & enable_ff)); // RQ5 RQ6
endmodule

// ### design/hpsc_host.sv
/*
 Host end: an APB slave holding the controller's registers and a sequencer that drives
 select, address, byte lanes, strobes and write data, and models the external read latch.
 Assumes the device end on the same clk and an APB master on the other side.
*/
`timescale 1ns/100ps
module hpsc_host (
    input  wire logic                  clk,
    input  wire logic                  reset,
    hpsc_if.host                       port,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       irq
);
    import hpsc_pkg::*;

    hpsc_host_state_t        state_ff;
    logic                    dirWrite_ff, busy_ff, mapped, apbWr, start;
    logic [ADDR_W-1:0]       addr_ff;
    logic [LANES-1:0]        bsel_ff;
    logic [DATA_W-1:0]       wdata_ff, rdata_ff, latch_ff;
    logic                    strobePrev_ff, loaded_ff, irqPrev_ff;
    logic [4:0]              cnt_ff;
    logic [1:0]              status_ff, enable_ff, events, nxt_status;

    assign mapped  = (paddr <= HR_EN) && (paddr[1:0] == 2'h0);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign apbWr   = psel && penable && pwrite && mapped;
    assign start   = apbWr && paddr == HR_CMD && pwdata[CMD_START] && !busy_ff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= '0;
        end else if (psel && !penable) begin
            case (paddr)
                HR_ADDR:  prdata <= {5'h0, addr_ff};
                HR_BSEL:  prdata <= {28'h0, bsel_ff};
                HR_WDATA: prdata <= wdata_ff;
                HR_RDATA: prdata <= rdata_ff;
                HR_LIVE:  prdata <= {30'h0, port.hostIrqOut, busy_ff};
                HR_STAT:  prdata <= {30'h0, status_ff};
                HR_EN:    prdata <= {30'h0, enable_ff};
                default:  prdata <= '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            addr_ff     <= '0;
            bsel_ff     <= '0;
            wdata_ff    <= '0;
            enable_ff   <= '0;
            dirWrite_ff <= 1'b0;
        end else if (apbWr && !busy_ff) begin
            case (paddr)
                HR_CMD:   dirWrite_ff <= pwdata[CMD_WRITE];
                HR_ADDR:  addr_ff <= pwdata[ADDR_W-1:0];
                HR_BSEL:  bsel_ff <= pwdata[LANES-1:0];
                HR_WDATA: wdata_ff <= pwdata;
                HR_EN:    enable_ff <= pwdata[1:0];
                default:  dirWrite_ff <= dirWrite_ff;
            endcase
        end else if (apbWr && paddr == HR_EN) begin
            enable_ff <= pwdata[1:0];
        end
    end

    // External read latch, loaded on the rising edge of the latch strobe.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strobePrev_ff <= 1'b0;
            latch_ff      <= '0;
            loaded_ff     <= 1'b0;
        end else begin
            strobePrev_ff <= port.readLatchStrobe;
            if (port.readLatchStrobe && !strobePrev_ff) begin
                latch_ff  <= port.readLatchData; // RQ4
                loaded_ff <= 1'b1;
            end else if (start) begin
                loaded_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff         <= HS_IDLE;
            busy_ff          <= 1'b0;
            cnt_ff           <= '0;
            rdata_ff         <= '0;
            port.hostSelectN <= 1'b1; // RQ3
            port.hostRdN     <= 1'b1;
            port.hostWrN     <= 1'b1;
        end else begin
            case (state_ff)
                HS_IDLE: begin
                    if (start) begin
                        busy_ff          <= 1'b1;
                        port.hostSelectN <= 1'b0; // RQ1
                        state_ff         <= HS_SETUP;
                    end
                end
                HS_SETUP: begin
                    cnt_ff <= '0;
                    if (dirWrite_ff) begin
                        port.hostWrN <= 1'b0; // RQ10 RQ11
                        state_ff     <= HS_WRLOW;
                    end else begin
                        port.hostRdN <= 1'b0; // RQ10 RQ11
                        state_ff     <= HS_RD;
                    end
                end
                HS_RD: begin
                    if (port.hostReadyOut && loaded_ff) begin // RQ8 RQ9
                        rdata_ff         <= latch_ff;
                        port.hostRdN     <= 1'b1;
                        port.hostSelectN <= 1'b1;
                        state_ff         <= HS_END;
                    end
                end
                HS_WRLOW: begin
                    cnt_ff <= cnt_ff + 5'h1;
                    if (cnt_ff == WR_LOW_CYC) begin
                        port.hostWrN <= 1'b1; // RQ12
                        state_ff     <= HS_WRWAIT;
                    end
                end
                HS_WRWAIT: begin
                    if (port.hostReadyOut && port.writeLatchOe) begin // RQ8 RQ9
                        port.hostSelectN <= 1'b1;
                        state_ff         <= HS_END;
                    end
                end
                HS_END: begin
                    if (!port.hostReadyOut) begin
                        busy_ff  <= 1'b0;
                        state_ff <= HS_IDLE;
                    end
                end
                default: state_ff <= HS_IDLE;
            endcase
        end
    end

    assign port.hostLongwordAddress = addr_ff;
    assign port.hostByteLaneSel     = bsel_ff;
    assign port.hostWriteData       = wdata_ff;

    always_comb begin
        events           = '0;
        events[HEV_DONE] = (state_ff == HS_END) && !port.hostReadyOut;
        events[HEV_IRQ]  = port.hostIrqOut && !irqPrev_ff;
        nxt_status       = status_ff;
        if (apbWr && paddr == HR_CLR) begin
            nxt_status = status_ff & ~pwdata[1:0];
        end
        nxt_status = nxt_status | events;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_ff  <= '0;
            irqPrev_ff <= 1'b0;
        end else begin
            status_ff  <= nxt_status;
            irqPrev_ff <= port.hostIrqOut;
        end
    end

    assign irq = |(status_ff & enable_ff);
endmodule

// ### testbench/hpsc_props.sv
/*
 Pin checker for the host port between the two ends.
 Assumes it sits beside the interface, on the same clk and reset.
*/
`timescale 1ns/100ps
module hpsc_props (
    input logic clk,
    input logic reset,
    input logic hostSelectN,
    input logic hostRdN,
    input logic hostWrN,
    input logic readLatchStrobe,
    input logic writeLatchOe,
    input logic hostReadyOut,
    input logic hostIrqOut,
    input logic localClockA,
    input logic localClockB
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    quiet_reset_a: assert property (
        $fell(reset) |-> !hostReadyOut && !readLatchStrobe && !writeLatchOe && !hostIrqOut)
        else $error("output active at reset release");
    rdy_sel_a: assert property ($rose(hostReadyOut) |-> !hostSelectN)
        else $error("ready without select");
    strobe_rd_a: assert property ($rose(readLatchStrobe) |-> !hostRdN && !hostSelectN)
        else $error("latch strobe without read");
    oe_wr_a: assert property ($rose(writeLatchOe) |-> hostRdN && !hostSelectN)
        else $error("latch enable without write");
    latch_excl_a: assert property (!(readLatchStrobe && writeLatchOe))
        else $error("strobe and enable together");
    rdwr_excl_a: assert property (hostRdN || hostWrN)
        else $error("read and write strobes together");
    strobe_hold_a: assert property ($rose(readLatchStrobe) |-> readLatchStrobe [*4])
        else $error("latch strobe too short");
    strobe_rdy_a: assert property ($rose(readLatchStrobe) |-> ##[1:8] hostReadyOut)
        else $error("no ready after strobe");
    oe_rdy_a: assert property ($rose(writeLatchOe) |-> ##[1:8] hostReadyOut)
        else $error("no ready after enable");
    rdy_latch_a: assert property (hostReadyOut |-> readLatchStrobe || writeLatchOe)
        else $error("ready without strobe or enable");
    rdy_drop_a: assert property (
        (hostSelectN && hostRdN && hostWrN) [*8] |-> ##[0:4] !hostReadyOut)
        else $error("ready stays high after access");
    clk_quad_a: assert property ($rose(localClockB) |=> $rose(localClockA))
        else $error("local clocks not a quarter apart");
    clk_period_a: assert property ($rose(localClockA) |-> ##4 $rose(localClockA))
        else $error("local clock period wrong");
    cover property ($rose(readLatchStrobe));
    cover property ($rose(writeLatchOe));
    cover property ($rose(hostIrqOut));
endmodule

// ### testbench/hpsc_bench.sv
/*
 Bench for the host port: both ends joined by the interface, driven over APB.
 Assumes the design package and interface are compiled first.
*/
`timescale 1ns/100ps
module hpsc_bench;
    import hpsc_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, irq, err, localIrqAN = 1'b1, localIrqBN = 1'b1;
    logic        localClockA, localClockB, cpuRun, selfBoot;
    logic [1:0]  localIrqReq;
    int          error_cnt = 0, cmp_count = 0;
    hpsc_if port ();
    always #20 clk = ~clk;
    hpsc_device i_hpsc_device (.clk(clk), .reset(reset), .port(port), .localIrqAN(localIrqAN),
        .localIrqBN(localIrqBN), .localClockA(localClockA), .localClockB(localClockB),
        .localIrqReq(localIrqReq), .cpuRun(cpuRun), .selfBoot(selfBoot));
    hpsc_host i_hpsc_host (.clk(clk), .reset(reset), .port(port), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    hpsc_props i_hpsc_props (.clk(clk), .reset(reset), .hostSelectN(port.hostSelectN),
        .hostRdN(port.hostRdN), .hostWrN(port.hostWrN), .readLatchStrobe(port.readLatchStrobe),
        .writeLatchOe(port.writeLatchOe), .hostReadyOut(port.hostReadyOut),
        .hostIrqOut(port.hostIrqOut), .localClockA(localClockA), .localClockB(localClockB));
    task automatic final_report();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            final_report();
        end
        rdat = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic access(input logic wr, input logic [26:0] a, input logic [3:0] bs,
                          input logic [31:0] d);
        int n;
        apb(1'b1, HR_CLR, 32'h1);
        apb(1'b1, HR_ADDR, {5'h0, a});
        apb(1'b1, HR_BSEL, {28'h0, bs});
        apb(1'b1, HR_WDATA, d);
        apb(1'b1, HR_CMD, {30'h0, wr, 1'b1});
        n = 0;
        do begin
            apb(1'b0, HR_STAT, 32'h0);
            n++;
        end while (rdat[HEV_DONE] !== 1'b1 && n < 100);
        if (n >= 100) begin
            error_cnt++;
            final_report();
        end
        apb(1'b0, HR_LIVE, 32'h0);
        check(32'(rdat[0]), 32'h0);
        apb(1'b0, HR_RDATA, 32'h0);
    endtask
    task automatic test_boot();
        check(32'(selfBoot), 32'h0);
        check(32'(cpuRun), 32'h0);
        check(32'(port.hostReadyOut), 32'h0);
        $display("test_boot done");
    endtask
    task automatic test_mem();
        access(1'b1, 27'h3, 4'hf, 32'h11223344);
        access(1'b1, 27'h4, 4'hf, 32'h55667788);
        access(1'b1, 27'h3, 4'h5, 32'haabbccdd);
        access(1'b0, 27'h3, 4'hf, 32'h0);
        check(rdat, 32'h11bb33dd);
        access(1'b0, 27'h4, 4'hf, 32'h0);
        check(rdat, 32'h55667788);
        $display("test_mem done");
    endtask
    task automatic test_halt();
        access(1'b1, 27'h4000000, 4'hf, 32'h0);
        check(32'(cpuRun), 32'h1);
        access(1'b1, 27'h4000000, 4'hf, 32'h1);
        check(32'(cpuRun), 32'h0);
        $display("test_halt done");
    endtask
    task automatic test_irq();
        apb(1'b1, HR_EN, 32'h2);
        apb(1'b1, HR_CLR, 32'h3);
        access(1'b1, 27'h4000000, 4'hf, 32'h2);
        apb(1'b0, HR_LIVE, 32'h0);
        check(32'(rdat[1]), 32'h1);
        check(32'(irq), 32'h1);
        access(1'b1, 27'h4000000, 4'hf, 32'h0);
        apb(1'b0, HR_LIVE, 32'h0);
        check(32'(rdat[1]), 32'h0);
        check(32'(irq), 32'h1);
        apb(1'b1, HR_EN, 32'h0);
        check(32'(irq), 32'h0);
        apb(1'b1, HR_CLR, 32'h2);
        apb(1'b1, HR_EN, 32'h2);
        check(32'(irq), 32'h0);
        $display("test_irq done");
    endtask
    task automatic test_fault();
        access(1'b1, 27'h4000003, 4'hf, 32'h1);
        access(1'b0, 27'h0000010, 4'hf, 32'h0);
        check(rdat, 32'h0);
        apb(1'b0, HR_LIVE, 32'h0);
        check(32'(rdat[1]), 32'h1);
        access(1'b1, 27'h4000002, 4'hf, 32'h1);
        apb(1'b0, HR_LIVE, 32'h0);
        check(32'(rdat[1]), 32'h0);
        access(1'b1, 27'h4000003, 4'hf, 32'h0);
        $display("test_fault done");
    endtask
    task automatic test_local_irq();
        localIrqAN <= 1'b0;
        localIrqBN <= 1'b0;
        @(posedge clk);
        check(32'(localIrqReq), 32'h0);
        repeat (6) @(posedge clk);
        check(32'(localIrqReq), 32'h3);
        access(1'b0, 27'h4000001, 4'hf, 32'h0);
        check(rdat & 32'h7, 32'h6);
        localIrqAN <= 1'b1;
        localIrqBN <= 1'b1;
        access(1'b1, 27'h4000002, 4'hf, 32'h6);
        access(1'b0, 27'h4000001, 4'hf, 32'h0);
        check(rdat & 32'h7, 32'h0);
        $display("test_local_irq done");
    endtask
    task automatic test_apb_map();
        apb(1'b0, 8'h24, 32'h0);
        check({rdat[30:0], err}, 32'h1);
        apb(1'b0, 8'h06, 32'h0);
        check(32'(err), 32'h1);
        $display("test_apb_map done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (10) @(posedge clk);
        test_boot();
        test_mem();
        test_halt();
        test_irq();
        test_fault();
        test_local_irq();
        test_apb_map();
        final_report();
    end
endmodule
